// ==== hw/dsp_mac_pkg.sv ====
package dsp_mac_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Instruction fields
    localparam int MAJOR_HI = 31;
    localparam int MAJOR_LO = 26;
    localparam int SRC_B_HI = 25;
    localparam int SRC_B_LO = 21;
    localparam int SRC_A_HI = 20;
    localparam int SRC_A_LO = 16;
    localparam int ACC_SEL_HI = 15;
    localparam int ACC_SEL_LO = 14;
    localparam int FUNC8_HI = 13;
    localparam int FUNC8_LO = 6;
    localparam int EXT_HI = 5;
    localparam int EXT_LO = 0;
    localparam int DEST_HI = 15;
    localparam int DEST_LO = 11;
    localparam int ZERO_BIT = 10;
    localparam int FUNC10_HI = 9;
    localparam int FUNC10_LO = 0;

    ////////////////////////////////////////////////////////////////////////
    // Encodings
    localparam logic [5:0] MAJOR_OPCODE_GROUP = 6'h00;
    localparam logic [5:0] EXTENDED_FUNCTION_GROUP = 6'h3c;
    localparam logic [7:0] FN_HALF_MSUB = 8'hb2;
    localparam logic [7:0] FN_Q15_MSUB = 8'hf2;
    localparam logic [7:0] FN_SIGNED_WORD = 8'h32;
    localparam logic [7:0] FN_UNSIGNED_WORD = 8'h72;
    localparam logic [9:0] FN_Q31_SAT_WORD = 10'h1d5;

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic constants and status bits
    localparam logic [31:0] Q31_MIN = 32'h80000000;
    localparam logic [31:0] Q31_MAX = 32'h7fffffff;
    localparam logic [15:0] Q15_MIN = 16'h8000;
    localparam int FLAG_Q31_BIT = 21;
    localparam int FLAG_ACC_BASE = 16;
    localparam int NUM_ACC = 4;
    localparam logic [63:0] ACC_RESET = 64'h0;
    localparam int MUL_STAGES = 2;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        OP_Q31_WORD,
        OP_HALF_MSUB,
        OP_Q15_MSUB,
        OP_SIGNED_WORD,
        OP_UNSIGNED_WORD
    } op_t;

    typedef enum logic {ST_IDLE, ST_BUSY} unit_state_t;

    typedef struct packed {
        op_t op;
        logic [1:0] sel;
        logic [4:0] dest;
        logic sat_hi;
        logic sat_lo;
    } tag_t;

    typedef struct packed {
        logic valid;
        logic [31:0] instr;
        logic [31:0] src_a;
        logic [31:0] src_b;
    } issue_t;

    typedef struct packed {
        logic valid;
        logic [4:0] dest;
        logic [31:0] data;
    } gpr_wr_t;

    typedef struct packed {
        logic valid;
        logic [1:0] sel;
        logic [63:0] value;
    } acc_upd_t;

endpackage : dsp_mac_pkg

// ==== hw/pipelined_multiplier.sv ====
`timescale 1ns/1ns
module pipelined_multiplier #(
    parameter int W = 17,
    parameter int STAGES = 2
) (
    // Clock, enable, reset
    input wire logic i_sys_clk,
    input wire logic i_clk_en,
    input wire logic i_resetn,
    // Operands
    input wire logic i_valid,
    input wire logic signed [W-1:0] i_a,
    input wire logic signed [W-1:0] i_b,
    // Product
    output logic o_valid,
    output logic [2*W-1:0] o_product
);

    logic [STAGES-1:0] vld_reg;
    logic [STAGES-1:0] vld_next;
    logic [STAGES-1:0][2*W-1:0] prod_reg;
    logic [STAGES-1:0][2*W-1:0] prod_next;
    logic signed [2*W-1:0] full_prod;

    ////////////////////////////////////////////////////////////////////////
    // Product enters stage 0, then shifts; retiming spreads the multiply
    always_comb begin
        full_prod = i_a * i_b;
        vld_next[0] = i_valid;
        prod_next[0] = full_prod;
        for (int s = 1; s < STAGES; s++) begin
            vld_next[s] = vld_reg[s-1];
            prod_next[s] = prod_reg[s-1];
        end
    end

    // Frozen while the enable is low
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            vld_reg <= '0;
            prod_reg <= '0;
        end else if (i_clk_en) begin
            vld_reg <= vld_next;
            prod_reg <= prod_next;
        end
    end

    assign o_valid = vld_reg[STAGES-1];
    assign o_product = prod_reg[STAGES-1];

endmodule : pipelined_multiplier

// ==== hw/dsp_multiply_accumulate_unit.sv ====
`timescale 1ns/1ns
module dsp_multiply_accumulate_unit #(
    parameter int STAGES = dsp_mac_pkg::MUL_STAGES
) (
    // Clock, enable, reset
    input wire logic i_sys_clk,
    input wire logic i_clk_en,
    input wire logic i_resetn,
    // Extension state from the core
    input wire logic i_dsp_present,
    input wire logic i_dsp_enabled,
    // Issue
    input wire dsp_mac_pkg::issue_t i_issue,
    output logic o_issue_ready,
    // Exceptions
    output logic o_reserved_exc,
    output logic o_dsp_disabled_exc,
    // Write-back and status
    output dsp_mac_pkg::gpr_wr_t o_gpr_wr,
    output dsp_mac_pkg::acc_upd_t o_acc_upd,
    output logic [31:0] o_status_set_mask,
    // Accumulator read port
    input wire logic i_acc_rd_valid,
    input wire logic [1:0] i_acc_rd_sel,
    output logic o_acc_rd_ready,
    output logic o_acc_rd_valid,
    output logic [63:0] o_acc_rd_data
);
    import dsp_mac_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    logic hit;
    op_t dec_op;
    logic [31:0] ins;
    logic [31:0] a;
    logic [31:0] b;
    logic attempt;
    logic accept;
    tag_t tag_next;

    assign ins = i_issue.instr;
    assign a = i_issue.src_a;
    assign b = i_issue.src_b;

    // Word-target form first; its low field never matches the group code
    always_comb begin
        hit = 1'b0;
        dec_op = OP_SIGNED_WORD;
        if (ins[MAJOR_HI:MAJOR_LO] == MAJOR_OPCODE_GROUP) begin
            if (!ins[ZERO_BIT] &&
                ins[FUNC10_HI:FUNC10_LO] == FN_Q31_SAT_WORD) begin
                hit = 1'b1;
                dec_op = OP_Q31_WORD;
            end else if (ins[EXT_HI:EXT_LO] == EXTENDED_FUNCTION_GROUP) begin
                case (ins[FUNC8_HI:FUNC8_LO])
                    FN_HALF_MSUB: begin
                        hit = 1'b1;
                        dec_op = OP_HALF_MSUB;
                    end
                    FN_Q15_MSUB: begin
                        hit = 1'b1;
                        dec_op = OP_Q15_MSUB;
                    end
                    FN_SIGNED_WORD: begin
                        hit = 1'b1;
                        dec_op = OP_SIGNED_WORD;
                    end
                    FN_UNSIGNED_WORD: begin
                        hit = 1'b1;
                        dec_op = OP_UNSIGNED_WORD;
                    end
                    default: hit = 1'b0;
                endcase
            end
        end
    end

    // Saturating cases are found on the operands, not on the product
    always_comb begin
        tag_next.op = dec_op;
        tag_next.sel = ins[ACC_SEL_HI:ACC_SEL_LO];
        tag_next.dest = ins[DEST_HI:DEST_LO];
        if (dec_op == OP_Q31_WORD) begin
            tag_next.sat_hi = (a == Q31_MIN) && (b == Q31_MIN);
        end else begin
            tag_next.sat_hi = (a[31:16] == Q15_MIN) && (b[31:16] == Q15_MIN);
        end
        tag_next.sat_lo = (a[15:0] == Q15_MIN) && (b[15:0] == Q15_MIN);
    end

    ////////////////////////////////////////////////////////////////////////
    // Multipliers: one word wide, one per halfword, equal latency
    unit_state_t state_reg;
    unit_state_t state_next;
    tag_t tag_reg;
    tag_t tag_hold;
    logic word_valid;
    logic [65:0] word_prod;
    logic [33:0] hi_prod;
    logic [33:0] lo_prod;
    logic [32:0] wa;
    logic [32:0] wb;
    logic uns;

    assign o_issue_ready = i_clk_en && (state_reg == ST_IDLE);
    assign attempt = i_issue.valid && o_issue_ready && hit;
    assign accept = attempt && i_dsp_present && i_dsp_enabled;
    assign uns = (dec_op == OP_UNSIGNED_WORD);
    assign wa = {a[31] & ~uns, a};
    assign wb = {b[31] & ~uns, b};

    pipelined_multiplier #(.W(33), .STAGES(STAGES)) u_word (
        .i_sys_clk(i_sys_clk),
        .i_clk_en(i_clk_en),
        .i_resetn(i_resetn),
        .i_valid(accept),
        .i_a(wa),
        .i_b(wb),
        .o_valid(word_valid),
        .o_product(word_prod)
    );

    pipelined_multiplier #(.W(17), .STAGES(STAGES)) u_hi (
        .i_sys_clk(i_sys_clk),
        .i_clk_en(i_clk_en),
        .i_resetn(i_resetn),
        .i_valid(accept),
        .i_a({a[31], a[31:16]}),
        .i_b({b[31], b[31:16]}),
        .o_valid(),
        .o_product(hi_prod)
    );

    pipelined_multiplier #(.W(17), .STAGES(STAGES)) u_lo (
        .i_sys_clk(i_sys_clk),
        .i_clk_en(i_clk_en),
        .i_resetn(i_resetn),
        .i_valid(accept),
        .i_a({a[15], a[15:0]}),
        .i_b({b[15], b[15:0]}),
        .o_valid(),
        .o_product(lo_prod)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencing: one operation in flight keeps the read interlock simple
    logic done;
    assign done = (state_reg == ST_BUSY) && word_valid && i_clk_en;

    always_comb begin
        state_next = state_reg;
        tag_hold = tag_reg;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    state_next = ST_BUSY;
                    tag_hold = tag_next;
                end
            end
            ST_BUSY: begin
                if (word_valid) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            state_reg <= ST_IDLE;
            tag_reg <= '0;
        end else if (i_clk_en) begin
            state_reg <= state_next;
            tag_reg <= tag_hold;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result arithmetic
    logic [31:0] q31_word;
    logic [31:0] prod_b;
    logic [31:0] prod_a;
    logic [32:0] half_diff;
    logic [63:0] half_delta;
    logic [31:0] q15_b;
    logic [31:0] q15_a;
    logic [63:0] q15_delta;
    logic [63:0] word_result;

    always_comb begin
        q31_word = tag_reg.sat_hi ? Q31_MAX : word_prod[62:31];
        prod_b = hi_prod[31:0];
        prod_a = lo_prod[31:0];
        half_diff = {prod_b[31], prod_b} - {prod_a[31], prod_a};
        half_delta = {{31{half_diff[32]}}, half_diff};
        q15_b = tag_reg.sat_hi ? Q31_MAX : {prod_b[30:0], 1'b0};
        q15_a = tag_reg.sat_lo ? Q31_MAX : {prod_a[30:0], 1'b0};
        q15_delta = {{32{q15_b[31]}}, q15_b} -
            {{32{q15_a[31]}}, q15_a};
        word_result = word_prod[63:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulators and registered outputs
    logic [NUM_ACC-1:0][63:0] acc_reg;
    logic [NUM_ACC-1:0][63:0] acc_next;
    logic [63:0] acc_cur;
    logic [63:0] acc_new;
    logic writes_acc;
    logic rd_fire;
    logic [63:0] rd_word;
    gpr_wr_t gpr_reg;
    gpr_wr_t gpr_next;
    acc_upd_t upd_reg;
    acc_upd_t upd_next;
    logic [31:0] mask_reg;
    logic [31:0] mask_next;
    logic rsv_reg;
    logic rsv_next;
    logic dis_reg;
    logic dis_next;
    logic rdv_reg;
    logic rdv_next;
    logic [63:0] rdd_reg;
    logic [63:0] rdd_next;

    assign writes_acc = (tag_reg.op != OP_Q31_WORD);
    assign acc_cur = acc_reg[tag_reg.sel];
    assign rd_word = acc_reg[i_acc_rd_sel];
    // Stall while the pending result targets the requested pair
    assign o_acc_rd_ready = i_clk_en && !((state_reg == ST_BUSY) &&
        writes_acc && (tag_reg.sel == i_acc_rd_sel));
    assign rd_fire = i_acc_rd_valid && o_acc_rd_ready;

    always_comb begin
        acc_next = acc_reg;
        gpr_next = '0;
        upd_next = '0;
        mask_next = '0;
        rsv_next = attempt && !i_dsp_present;
        dis_next = attempt && i_dsp_present && !i_dsp_enabled;
        rdv_next = rd_fire;
        rdd_next = rd_fire ? rd_word : rdd_reg;
        case (tag_reg.op)
            OP_HALF_MSUB: acc_new = acc_cur + half_delta;
            OP_Q15_MSUB: acc_new = acc_cur + q15_delta;
            default: acc_new = word_result;
        endcase
        if (done) begin
            if (writes_acc) begin
                acc_next[tag_reg.sel] = acc_new;
                upd_next = '{valid: 1'b1, sel: tag_reg.sel, value: acc_new};
            end else begin
                // Pairs stay as they were, the primary one included
                gpr_next = '{valid: 1'b1, dest: tag_reg.dest,
                    data: q31_word};
                mask_next[FLAG_Q31_BIT] = tag_reg.sat_hi;
            end
            if (tag_reg.op == OP_Q15_MSUB) begin
                mask_next[FLAG_ACC_BASE + int'(tag_reg.sel)] =
                    tag_reg.sat_hi | tag_reg.sat_lo;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            acc_reg <= {NUM_ACC{ACC_RESET}};
            gpr_reg <= '0;
            upd_reg <= '0;
            mask_reg <= '0;
            rsv_reg <= 1'b0;
            dis_reg <= 1'b0;
            rdv_reg <= 1'b0;
            rdd_reg <= '0;
        end else if (i_clk_en) begin
            acc_reg <= acc_next;
            gpr_reg <= gpr_next;
            upd_reg <= upd_next;
            mask_reg <= mask_next;
            rsv_reg <= rsv_next;
            dis_reg <= dis_next;
            rdv_reg <= rdv_next;
            rdd_reg <= rdd_next;
        end
    end

    assign o_gpr_wr = gpr_reg;
    assign o_acc_upd = upd_reg;
    assign o_status_set_mask = mask_reg;
    assign o_reserved_exc = rsv_reg;
    assign o_dsp_disabled_exc = dis_reg;
    assign o_acc_rd_valid = rdv_reg;
    assign o_acc_rd_data = rdd_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks; latency bound allows short enable-low gaps only
    localparam int LAT_MAX = 40;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    property p_q31_clip;
        accept && dec_op == OP_Q31_WORD && a == Q31_MIN && b == Q31_MIN
        |-> ##[1:LAT_MAX] (o_gpr_wr.valid && o_gpr_wr.data == Q31_MAX);
    endproperty
    a_q31_clip: assert property (p_q31_clip)
        else $error("clipped Q31 word product not written");

    property p_q31_shift;
        done && tag_reg.op == OP_Q31_WORD && !tag_reg.sat_hi
        |=> o_gpr_wr.valid && o_gpr_wr.data == $past(word_prod[62:31]);
    endproperty
    a_q31_shift: assert property (p_q31_shift)
        else $error("Q31 word product upper half wrong");

    property p_q31_flag;
        o_status_set_mask[FLAG_Q31_BIT]
        |-> o_gpr_wr.valid && o_gpr_wr.data == Q31_MAX && !o_acc_upd.valid;
    endproperty
    a_q31_flag: assert property (p_q31_flag)
        else $error("bit 21 set without a clipped word result");

    property p_q31_keep_acc;
        done && tag_reg.op == OP_Q31_WORD |=> $stable(acc_reg);
    endproperty
    a_q31_keep_acc: assert property (p_q31_keep_acc)
        else $error("Q31 word product disturbed an accumulator");

    property p_exc;
        attempt && !(i_dsp_present && i_dsp_enabled)
        |=> (o_reserved_exc ^ o_dsp_disabled_exc) && state_reg == ST_IDLE;
    endproperty
    a_exc: assert property (p_exc)
        else $error("refused instruction without one exception");

    property p_half_no_flag;
        done && tag_reg.op == OP_HALF_MSUB |=> o_status_set_mask == 32'h0;
    endproperty
    a_half_no_flag: assert property (p_half_no_flag)
        else $error("integer halfword accumulate touched a flag");

    property p_q15_flag_sel;
        o_status_set_mask[19:16] != 4'h0
        |-> o_acc_upd.valid && o_status_set_mask[19:16] == 4'h1 << o_acc_upd.sel;
    endproperty
    a_q15_flag_sel: assert property (p_q15_flag_sel)
        else $error("accumulator flag bit does not match select");

    property p_rd_stall;
        state_reg == ST_BUSY && writes_acc && tag_reg.sel == i_acc_rd_sel
        |-> !o_acc_rd_ready;
    endproperty
    a_rd_stall: assert property (p_rd_stall)
        else $error("read of pending accumulator not stalled");

    property p_rd_data;
        rd_fire |=> o_acc_rd_valid && o_acc_rd_data == $past(rd_word);
    endproperty
    a_rd_data: assert property (p_rd_data)
        else $error("accumulator read returned wrong pair");

    property p_upd_lands;
        o_acc_upd.valid |-> acc_reg[o_acc_upd.sel] == o_acc_upd.value;
    endproperty
    a_upd_lands: assert property (p_upd_lands)
        else $error("announced update not held in accumulator");

    c_q31_sat: cover property (o_status_set_mask[FLAG_Q31_BIT]);
    c_q15_sat: cover property (o_status_set_mask[19:16] != 4'h0);
    c_stall: cover property (i_acc_rd_valid && !o_acc_rd_ready);
    c_unsigned: cover property (done && tag_reg.op == OP_UNSIGNED_WORD);

endmodule : dsp_multiply_accumulate_unit

// ==== sim/core_issue_model.sv ====
`timescale 1ns/1ns
module core_issue_model
    import dsp_mac_pkg::*;
(
    // Clock
    input wire logic i_sys_clk,
    // Request from the bench
    input wire logic i_req,
    input wire logic [31:0] i_instr,
    input wire logic [31:0] i_src_a,
    input wire logic [31:0] i_src_b,
    // Issue handshake
    input wire logic i_issue_ready,
    output dsp_mac_pkg::issue_t o_issue,
    output logic o_busy
);
    issue_t offer_reg = '0;

    assign o_issue = offer_reg;
    assign o_busy = offer_reg.valid;

    ////////////////////////////////////////////////////////////////////////
    // Offer held until taken; fields scrambled after, so a stale word
    // never looks like the one just consumed
    always @(posedge i_sys_clk) begin
        if (offer_reg.valid && i_issue_ready) begin
            offer_reg <= '{1'b0, ~offer_reg.instr, ~offer_reg.src_a,
                ~offer_reg.src_b};
        end else if (i_req && !offer_reg.valid) begin
            offer_reg <= '{1'b1, i_instr, i_src_a, i_src_b};
        end
    end
endmodule : core_issue_model

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    import dsp_mac_pkg::*;

    typedef struct packed {
        op_t op;
        logic [1:0] sel;
        logic [31:0] a;
        logic [31:0] b;
        logic [63:0] exp;
        logic [31:0] mask;
    } row_t;

    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic present = 1'b1;
    logic enabled = 1'b1;
    logic req = 1'b0;
    logic rv = 1'b0;
    logic [1:0] rsel = 2'h0;
    logic [31:0] ins = 32'h0;
    logic [31:0] sa = 32'h0;
    logic [31:0] sb = 32'h0;
    issue_t issue;
    gpr_wr_t general_register;
    acc_upd_t upd;
    logic [31:0] mask;
    logic [63:0] rd_data;
    logic busy, iss_ready, res_exc, dis_exc, rd_ready, rd_valid;
    logic [63:0] exp_acc [4];
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;

    // Ordinary cases; earlier rows seed the accumulators for later ones
    row_t rows [13] = '{
        '{OP_SIGNED_WORD, 2'h0, 32'hffffffff, 32'h00000002,
          64'hfffffffffffffffe, 32'h0},
        '{OP_UNSIGNED_WORD, 2'h1, 32'hffffffff, 32'h00000002,
          64'h00000001fffffffe, 32'h0},
        '{OP_SIGNED_WORD, 2'h2, 32'h80000000, 32'h80000000,
          64'h4000000000000000, 32'h0},
        '{OP_UNSIGNED_WORD, 2'h3, 32'hffffffff, 32'hffffffff,
          64'hfffffffe00000001, 32'h0},
        '{OP_HALF_MSUB, 2'h0, 32'h00030002, 32'h00040005,
          64'h0, 32'h0},
        '{OP_HALF_MSUB, 2'h1, 32'hffff0001, 32'h00017fff,
          64'h00000001ffff7ffe, 32'h0},
        '{OP_Q15_MSUB, 2'h2, 32'h80000000, 32'h80000000,
          64'h400000007fffffff, 32'h00040000},
        '{OP_Q15_MSUB, 2'h3, 32'h00008000, 32'h00008000,
          64'hfffffffd80000002, 32'h00080000},
        '{OP_Q15_MSUB, 2'h0, 32'h40002000, 32'h40004000,
          64'h0000000010000000, 32'h0},
        '{OP_Q15_MSUB, 2'h0, 32'h80000001, 32'h80000001,
          64'h000000008ffffffd, 32'h00010000},
        '{OP_Q15_MSUB, 2'h1, 32'h80008000, 32'h80008000,
          64'h00000001ffff7ffe, 32'h00020000},
        '{OP_Q31_WORD, 2'h0, 32'h80000000, 32'h80000000,
          64'h7fffffff, 32'h00200000},
        '{OP_Q31_WORD, 2'h0, 32'hffffffff, 32'h80000000,
          64'h00000001, 32'h0}
    };

    always #5 sys_clk = ~sys_clk;

    dsp_multiply_accumulate_unit #(.STAGES(1)) dsp_multiply_accumulate_unit_i (
        .i_sys_clk(sys_clk), .i_clk_en(ce), .i_resetn(resetn),
        .i_dsp_present(present), .i_dsp_enabled(enabled),
        .i_issue(issue), .o_issue_ready(iss_ready),
        .o_reserved_exc(res_exc), .o_dsp_disabled_exc(dis_exc),
        .o_gpr_wr(general_register), .o_acc_upd(upd), .o_status_set_mask(mask),
        .i_acc_rd_valid(rv), .i_acc_rd_sel(rsel),
        .o_acc_rd_ready(rd_ready), .o_acc_rd_valid(rd_valid),
        .o_acc_rd_data(rd_data));

    core_issue_model core_issue_model_i (
        .i_sys_clk(sys_clk), .i_req(req), .i_instr(ins), .i_src_a(sa),
        .i_src_b(sb), .i_issue_ready(iss_ready), .o_issue(issue),
        .o_busy(busy));

    ////////////////////////////////////////////////////////////////////////
    task chk(input string name, input logic [63:0] got,
        input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task close_out;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    // Encodings written out bit for bit, not taken from the package
    function automatic logic [31:0] mk(input op_t op, input logic [1:0] s);
        logic [7:0] fn;
        if (op == OP_Q31_WORD) begin
            return {6'h00, 5'h02, 5'h01, 5'h07, 1'b0, 10'h1d5};
        end
        fn = (op == OP_HALF_MSUB) ? 8'hb2 : (op == OP_Q15_MSUB) ? 8'hf2 :
            (op == OP_SIGNED_WORD) ? 8'h32 : 8'h72;
        return {6'h00, 5'h02, 5'h01, s, fn, 6'h3c};
    endfunction : mk

    // One issue; gap holds the clock enable low while the offer waits
    task automatic do_op(input row_t r, input logic [31:0] w, input int gap,
        input logic [1:0] exc, input logic want);
        int k;
        logic to_gpr;
        to_gpr = (r.op == OP_Q31_WORD);
        @(posedge sys_clk) begin
            req <= 1'b1;
            ins <= w;
            sa <= r.a;
            sb <= r.b;
            rsel <= r.sel;
            ce <= (gap == 0);
        end
        @(posedge sys_clk) req <= 1'b0;
        repeat (gap) begin
            @(negedge sys_clk);
            chk("ready_gated", iss_ready, 64'h0);
        end
        @(posedge sys_clk) ce <= 1'b1;
        repeat (20) begin
            @(negedge sys_clk);
            if (busy !== 1'b1) break;
        end
        chk("reserved_exc", res_exc, 64'(exc[1]));
        chk("disabled_exc", dis_exc, 64'(exc[0]));
        if (want) begin
            chk("issue_busy", iss_ready, 64'h0);
            if (!to_gpr) chk("rd_stall", rd_ready, 64'h0);
        end
        k = 0;
        while (k < 8 && upd.valid !== 1'b1 && general_register.valid !== 1'b1) begin
            @(negedge sys_clk);
            k++;
        end
        chk("latency", 64'(k), want ? 64'h1 : 64'h8);
        if (want) begin
            chk("mask", mask, 64'(r.mask));
            chk("gpr_valid", general_register.valid, 64'(to_gpr));
            if (to_gpr) begin
                chk("gpr_data", general_register.data, r.exp);
                chk("gpr_dest", general_register.dest, 64'h7);
            end else begin
                chk("acc_sel", upd.sel, 64'(r.sel));
                chk("acc_value", upd.value, r.exp);
                exp_acc[r.sel] = r.exp;
            end
        end
    endtask : do_op

    task automatic rd_acc(input logic [1:0] s);
        @(posedge sys_clk) begin
            rv <= 1'b1;
            rsel <= s;
        end
        repeat (20) begin
            @(negedge sys_clk);
            if (rd_ready === 1'b1) break;
        end
        @(posedge sys_clk) rv <= 1'b0;
        @(negedge sys_clk);
        chk("rd_valid", rd_valid, 64'h1);
        chk("rd_data", rd_data, exp_acc[s]);
    endtask : rd_acc

    task automatic check_all;
        for (int s = 0; s < 4; s++) begin
            rd_acc(2'(s));
        end
    endtask : check_all

    ////////////////////////////////////////////////////////////////////////
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            close_out;
        end
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("rst_ready", iss_ready, 64'h1);
        chk("rst_out", {upd.valid, general_register.valid, res_exc, dis_exc}, 64'h0);
        chk("rst_mask", mask, 64'h0);
        @(posedge sys_clk) resetn <= 1'b1;
        for (int s = 0; s < 4; s++) exp_acc[s] = 64'h0;
        check_all;
        foreach (rows[i]) begin
            do_op(rows[i], mk(rows[i].op, rows[i].sel), (i == 5) ? 2 : 0,
                2'b00, 1'b1);
            check_all;
        end
        // Wrong extended group and wrong major field are not ours
        do_op(rows[0], mk(OP_SIGNED_WORD, 2'h0) ^ 32'h1, 0, 2'b00, 1'b0);
        do_op(rows[1], mk(OP_UNSIGNED_WORD, 2'h1) | 32'h04000000, 0, 2'b00,
            1'b0);
        @(posedge sys_clk) enabled <= 1'b0;
        do_op(rows[2], mk(OP_SIGNED_WORD, 2'h2), 0, 2'b01, 1'b0);
        @(posedge sys_clk) present <= 1'b0;
        do_op(rows[6], mk(OP_Q15_MSUB, 2'h2), 0, 2'b10, 1'b0);
        @(posedge sys_clk) begin
            present <= 1'b1;
            enabled <= 1'b1;
        end
        check_all;
        close_out;
    end
endmodule : tb_top
